// File: link_ctrl_pkg.sv
// shared types and constants for the link control state machine
package link_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_FAIL         = 3'h0,
    ST_FAIL_BLOCKED = 3'h1,
    ST_BLOCKED      = 3'h2,
    ST_LOCAL_UNBLK  = 3'h3,
    ST_REMOTE_UNBLK = 3'h4,
    ST_OPER         = 3'h5,
    ST_REMOTE_IDENT = 3'h6,
    ST_LOCAL_IDENT  = 3'h7
  } link_state_t;

  localparam link_state_t STATE_RESET = ST_BLOCKED;
  localparam logic [7:0] LINK_ID_RESET = 8'h00;

  // event inputs, one-cycle pulses
  typedef struct packed {
    logic layer1_down_ind;
    logic layer1_up_ind;
    logic ident_ok;
    logic ident_fail;
  } l1_evt_t;

  typedef struct packed {
    logic block_req;
    logic block_req_deferred;
    logic block_req_nondeferred;
    logic block_immediate;
    logic unblock_req;
    logic ident_req;
    logic ident_accept;
    logic ident_reject;
    logic internal_fail;
  } mgmt_evt_t;

  typedef struct packed {
    logic exchange_unblock_elem;
    logic block_ind;
    logic peer_ident_request;
    logic peer_ident_ack;
    logic ident_release;
    logic ident_reject;
  } peer_evt_t;

  // outgoing element toward the peer, with the link identifier
  typedef struct packed {
    logic access_unblock_elem;
    logic block_ind;
    logic block_req_deferred;
    logic block_req_nondeferred;
    logic peer_ident_request;
    logic peer_ident_ack;
    logic ident_release;
    logic ident_reject;
    logic [7:0] link_id;
  } peer_msg_t;

  typedef struct packed {
    logic mgmt_unblock_ind;
    logic mgmt_block_ind;
    logic unblock_req_ind;
    logic ident_req_ind;
    logic ident_ok_ind;
    logic ident_fail_ind;
    logic ident_reject_ind;
    logic ident_release_ind;
    logic protect_start;
  } mgmt_out_t;

  function automatic logic is_oper(input link_state_t s);
    return (s == ST_OPER) || (s == ST_REMOTE_IDENT) || (s == ST_LOCAL_IDENT);
  endfunction

endpackage

// File: link_event_arbiter.sv
// picks one event per cycle from the three event sources
`timescale 1ns/1ps
`default_nettype none
module link_event_arbiter
  import link_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire l1_evt_t l1_in,
  input wire mgmt_evt_t mgmt_in,
  input wire peer_evt_t peer_in,
  output l1_evt_t l1_sel,
  output mgmt_evt_t mgmt_sel,
  output peer_evt_t peer_sel
);

  typedef struct packed {
    l1_evt_t l1;
    mgmt_evt_t mgmt;
    peer_evt_t peer;
  } arb_state_t;

  arb_state_t state_reg;
  arb_state_t state_next;

  // layer 1 first, then peer, then management; pending ones wait
  always_comb begin
    arb_state_t pend;
    pend = state_reg;
    pend.l1 = pend.l1 | l1_in;
    pend.mgmt = pend.mgmt | mgmt_in;
    pend.peer = pend.peer | peer_in;
    l1_sel = '0;
    mgmt_sel = '0;
    peer_sel = '0;
    if (pend.l1.layer1_down_ind) begin
      l1_sel.layer1_down_ind = 1'b1;
    end else if (pend.l1.layer1_up_ind) begin
      l1_sel.layer1_up_ind = 1'b1;
    end else if (pend.l1.ident_ok) begin
      l1_sel.ident_ok = 1'b1;
    end else if (pend.l1.ident_fail) begin
      l1_sel.ident_fail = 1'b1;
    end else if (pend.peer != '0) begin
      for (int i = $bits(peer_evt_t) - 1; i >= 0; i--) begin
        if (pend.peer[i] && peer_sel == '0) begin
          peer_sel[i] = 1'b1;
        end
      end
    end else begin
      for (int i = $bits(mgmt_evt_t) - 1; i >= 0; i--) begin
        if (pend.mgmt[i] && mgmt_sel == '0) begin
          mgmt_sel[i] = 1'b1;
        end
      end
    end
    state_next.l1 = pend.l1 & ~l1_sel;
    state_next.mgmt = pend.mgmt & ~mgmt_sel;
    state_next.peer = pend.peer & ~peer_sel;
    if (!clk_en) begin
      l1_sel = '0;
      mgmt_sel = '0;
      peer_sel = '0;
      state_next = state_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

// File: link_control_fsm.sv
// access-network link control state machine for one link
// Operation
// - five non-operational substates: fail, fail-blocked, blocked, local and remote unblock.
// - three operational substates: operational, remote identification, local identification.
// - operation entered only once both ends acknowledged unblocking.
// - unblock indication on entering operation, block indication on leaving it.
// - unblock, deferred and non-deferred block request need peer acknowledgement; plain block request and immediate block do not.
// - block request during layer-1 failure sends block indication, enters fail-blocked.
// - layer-1 recovery in fail-blocked goes to blocked with block indication.
// - unblock request from either side during failure goes to fail-blocked.
// - peer identification request during failure goes to fail-blocked.
// - non-operational: no control channel, no standby, no bearers, identification rejected.
// - layer-1 down indication enters layer-1 failure.
// - layer-1 loss while blocked, or misalignment, enters fail-blocked.
// - local unblock awaits peer confirmation; remote unblock awaits ours.
// - no timeout in either unblock-pending substate.
// - remote identification drives identification bit zero, waits peer release.
// - local identification awaits ack, then layer-1 answer, reports, releases.
// - failed urgent non-deferred block request may block immediately.
// - internal failure blocks immediately and starts protection switching.
// - every outgoing element carries the link identifier.
// - procedures apply even for a single-link interface.
// - exchange identification request wins over ours on collision.
// - identification bit zero while identification signalled, one otherwise.
`timescale 1ns/1ps
`default_nettype none
module link_control_fsm
  import link_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] link_id,
  input wire l1_evt_t l1_in,
  input wire mgmt_evt_t mgmt_in,
  input wire peer_evt_t peer_in,
  output peer_msg_t peer_msg,
  output mgmt_out_t mgmt_out,
  output logic layer1_ident_info_req,
  output logic ident_spare_bit,
  output logic link_operational,
  output logic cchan_allowed,
  output logic bearer_allowed,
  output link_state_t link_state
);

  typedef struct packed {
    link_state_t st;
    logic ack_seen;
    logic ident_bit_zero;
    logic info_req;
    logic [7:0] id;
    peer_msg_t msg;
    mgmt_out_t mo;
  } fsm_state_t;

  fsm_state_t state_reg;
  fsm_state_t state_next;
  l1_evt_t l1;
  mgmt_evt_t mg;
  peer_evt_t pe;

  link_event_arbiter u_arb (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .l1_in(l1_in),
    .mgmt_in(mgmt_in),
    .peer_in(peer_in),
    .l1_sel(l1),
    .mgmt_sel(mg),
    .peer_sel(pe)
  );

  always_comb begin
    fsm_state_t n;
    n = state_reg;
    n.msg = '0;
    n.mo = '0;
    n.info_req = 1'b0;
    n.id = link_id;
    n.msg.link_id = link_id;
    if (l1.layer1_down_ind) begin
      case (state_reg.st)
        ST_FAIL, ST_FAIL_BLOCKED: n.st = state_reg.st;
        ST_BLOCKED: n.st = ST_FAIL_BLOCKED;
        default: n.st = ST_FAIL;
      endcase
    end else if (l1.layer1_up_ind) begin
      if (state_reg.st == ST_FAIL_BLOCKED) begin
        n.st = ST_BLOCKED;
        n.mo.mgmt_block_ind = 1'b1;
      end else if (state_reg.st == ST_FAIL) begin
        n.st = ST_BLOCKED;
        n.mo.mgmt_block_ind = 1'b1;
      end
    end else if ((l1.ident_ok || l1.ident_fail) && state_reg.st == ST_LOCAL_IDENT && state_reg.ack_seen) begin
      n.mo.ident_ok_ind = l1.ident_ok;
      n.mo.ident_fail_ind = l1.ident_fail;
      n.msg.ident_release = 1'b1;
      n.st = ST_OPER;
      n.ack_seen = 1'b0;
    end else if (pe != '0) begin
      case (state_reg.st)
        ST_FAIL: begin
          if (pe.exchange_unblock_elem) begin
            n.st = ST_FAIL_BLOCKED;
          end else if (pe.peer_ident_request) begin
            n.st = ST_FAIL_BLOCKED;
            n.msg.ident_reject = 1'b1;
          end
        end
        ST_FAIL_BLOCKED, ST_BLOCKED: begin
          if (pe.exchange_unblock_elem && state_reg.st == ST_BLOCKED) begin
            n.st = ST_REMOTE_UNBLK;
            n.mo.unblock_req_ind = 1'b1;
          end else if (pe.peer_ident_request) begin
            n.msg.ident_reject = 1'b1;
          end
        end
        ST_LOCAL_UNBLK: begin
          if (pe.exchange_unblock_elem) begin
            n.st = ST_OPER;
            n.mo.mgmt_unblock_ind = 1'b1;
          end else if (pe.block_ind) begin
            n.st = ST_BLOCKED;
            n.mo.mgmt_block_ind = 1'b1;
          end else if (pe.peer_ident_request) begin
            n.msg.ident_reject = 1'b1;
          end
        end
        ST_REMOTE_UNBLK: begin
          if (pe.block_ind) begin
            n.st = ST_BLOCKED;
            n.mo.mgmt_block_ind = 1'b1;
          end else if (pe.peer_ident_request) begin
            n.msg.ident_reject = 1'b1;
          end
        end
        ST_OPER: begin
          if (pe.block_ind) begin
            n.st = ST_BLOCKED;
            n.mo.mgmt_block_ind = 1'b1;
          end else if (pe.peer_ident_request) begin
            n.mo.ident_req_ind = 1'b1;
          end
        end
        ST_REMOTE_IDENT: begin
          if (pe.ident_release) begin
            n.st = ST_OPER;
            n.ident_bit_zero = 1'b0;
            n.mo.ident_release_ind = 1'b1;
          end else if (pe.block_ind) begin
            n.st = ST_BLOCKED;
            n.ident_bit_zero = 1'b0;
            n.mo.mgmt_block_ind = 1'b1;
          end
        end
        default: begin
          if (pe.block_ind) begin
            n.st = ST_BLOCKED;
            n.ack_seen = 1'b0;
            n.mo.mgmt_block_ind = 1'b1;
          end else if (pe.peer_ident_request && !state_reg.ack_seen) begin
            n.ack_seen = 1'b0;
            n.st = ST_OPER;
            n.mo.ident_req_ind = 1'b1;
          end else if (pe.peer_ident_ack && !state_reg.ack_seen) begin
            n.ack_seen = 1'b1;
            n.info_req = 1'b1;
          end else if (pe.ident_reject && !state_reg.ack_seen) begin
            n.st = ST_OPER;
            n.mo.ident_reject_ind = 1'b1;
          end
        end
      endcase
    end else if (mg != '0) begin
      if (mg.internal_fail || mg.block_immediate) begin
        if (is_oper(state_reg.st)) begin
          n.mo.mgmt_block_ind = 1'b1;
        end
        if (state_reg.st == ST_FAIL) begin
          n.st = ST_FAIL_BLOCKED;
        end else if (state_reg.st != ST_FAIL_BLOCKED) begin
          n.st = ST_BLOCKED;
        end
        n.msg.block_ind = 1'b1;
        n.mo.protect_start = mg.internal_fail;
        n.ident_bit_zero = 1'b0;
        n.ack_seen = 1'b0;
      end else if (mg.block_req) begin
        if (state_reg.st == ST_FAIL) begin
          n.st = ST_FAIL_BLOCKED;
          n.msg.block_ind = 1'b1;
        end else if (state_reg.st != ST_FAIL_BLOCKED) begin
          if (is_oper(state_reg.st)) begin
            n.mo.mgmt_block_ind = 1'b1;
          end
          n.st = ST_BLOCKED;
          n.msg.block_ind = 1'b1;
          n.ident_bit_zero = 1'b0;
          n.ack_seen = 1'b0;
        end
      end else if (mg.block_req_deferred || mg.block_req_nondeferred) begin
        if (is_oper(state_reg.st)) begin
          n.msg.block_req_deferred = mg.block_req_deferred;
          n.msg.block_req_nondeferred = mg.block_req_nondeferred;
        end
      end else if (mg.unblock_req) begin
        case (state_reg.st)
          ST_FAIL: n.st = ST_FAIL_BLOCKED;
          ST_BLOCKED: begin
            n.st = ST_LOCAL_UNBLK;
            n.msg.access_unblock_elem = 1'b1;
          end
          ST_REMOTE_UNBLK: begin
            n.st = ST_OPER;
            n.msg.access_unblock_elem = 1'b1;
            n.mo.mgmt_unblock_ind = 1'b1;
          end
          default: n.st = state_reg.st;
        endcase
      end else if (mg.ident_req) begin
        if (state_reg.st == ST_OPER) begin
          n.st = ST_LOCAL_IDENT;
          n.ack_seen = 1'b0;
          n.msg.peer_ident_request = 1'b1;
        end else begin
          n.mo.ident_reject_ind = 1'b1;
        end
      end else if (mg.ident_accept && state_reg.st == ST_OPER) begin
        n.st = ST_REMOTE_IDENT;
        n.ident_bit_zero = 1'b1;
        n.msg.peer_ident_ack = 1'b1;
      end else if (mg.ident_reject && state_reg.st == ST_OPER) begin
        n.msg.ident_reject = 1'b1;
      end
    end
    if (is_oper(state_reg.st) && !is_oper(n.st)) begin
      n.mo.mgmt_block_ind = 1'b1;
      n.ident_bit_zero = 1'b0;
    end
    state_next = clk_en ? n : state_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= '0;
      state_reg.st <= STATE_RESET;
      state_reg.id <= LINK_ID_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign peer_msg = state_reg.msg;
  assign mgmt_out = state_reg.mo;
  assign layer1_ident_info_req = state_reg.info_req;
  assign ident_spare_bit = ~state_reg.ident_bit_zero;
  assign link_state = state_reg.st;
  assign link_operational = is_oper(state_reg.st);
  assign cchan_allowed = is_oper(state_reg.st);
  assign bearer_allowed = is_oper(state_reg.st);

endmodule
`default_nettype wire

// File: link_control_fsm_chk.sv
// assertions on the ports of the link control state machine
`timescale 1ns/1ps
`default_nettype none
module link_control_fsm_chk
  import link_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] link_id,
  input wire l1_evt_t l1_in,
  input wire mgmt_evt_t mgmt_in,
  input wire peer_evt_t peer_in,
  input wire peer_msg_t peer_msg,
  input wire mgmt_out_t mgmt_out,
  input wire logic layer1_ident_info_req,
  input wire logic ident_spare_bit,
  input wire logic link_operational,
  input wire logic cchan_allowed,
  input wire logic bearer_allowed,
  input wire link_state_t link_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic pr_go;
  logic mg_go;
  // a lower priority source is only served when the higher ones are quiet
  assign pr_go = clk_en && l1_in == '0;
  assign mg_go = pr_go && peer_in == '0;
  sequence s_enter;
    mgmt_out.mgmt_unblock_ind && !mgmt_out.mgmt_block_ind;
  endsequence
  sequence s_recover;
    link_state == ST_BLOCKED && mgmt_out.mgmt_block_ind;
  endsequence
  property p_unblk;
    $rose(link_operational) |-> $past(link_state) inside {ST_LOCAL_UNBLK, ST_REMOTE_UNBLK};
  endproperty
  property p_enter;
    $rose(link_operational) |-> s_enter;
  endproperty
  property p_leave;
    $fell(link_operational) |-> mgmt_out.mgmt_block_ind;
  endproperty
  property p_oper;
    link_operational == (link_state inside {ST_OPER, ST_REMOTE_IDENT, ST_LOCAL_IDENT})
      && cchan_allowed == link_operational && bearer_allowed == link_operational;
  endproperty
  property p_down;
    clk_en && l1_in.layer1_down_ind && link_state != ST_BLOCKED && link_state != ST_FAIL_BLOCKED
      |=> link_state == ST_FAIL;
  endproperty
  property p_down_blk;
    clk_en && l1_in.layer1_down_ind && link_state == ST_BLOCKED |=> link_state == ST_FAIL_BLOCKED;
  endproperty
  property p_up;
    clk_en && l1_in == 4'h4 && link_state == ST_FAIL_BLOCKED |=> s_recover;
  endproperty
  property p_fail_blk;
    link_state == ST_FAIL && mg_go && mgmt_in == 9'h100 |=> link_state == ST_FAIL_BLOCKED && peer_msg.block_ind;
  endproperty
  property p_misalign;
    link_state == ST_FAIL && pr_go && (peer_in == 6'h20 || peer_in == 6'h08 || mg_go && mgmt_in == 9'h010)
      |=> link_state == ST_FAIL_BLOCKED;
  endproperty
  property p_reject;
    link_state == ST_BLOCKED && pr_go && peer_in == 6'h08 |=> peer_msg.ident_reject;
  endproperty
  property p_spare;
    ident_spare_bit == (link_state != ST_REMOTE_IDENT);
  endproperty
  property p_info;
    layer1_ident_info_req |-> link_state == ST_LOCAL_IDENT;
  endproperty
  property p_id;
    clk_en |=> peer_msg.link_id == $past(link_id);
  endproperty
  property p_intfail;
    link_operational && mg_go && mgmt_in == 9'h001 |=> mgmt_out.protect_start && peer_msg.block_ind;
  endproperty
  a_unblk: assert property (p_unblk) else $error("operation entered without unblock");
  a_enter: assert property (p_enter) else $error("no unblock indication");
  a_leave: assert property (p_leave) else $error("no block indication");
  a_oper: assert property (p_oper) else $error("channel use wrong");
  a_down: assert property (p_down) else $error("layer down not failed");
  a_down_blk: assert property (p_down_blk) else $error("blocked loss wrong");
  a_up: assert property (p_up) else $error("recovery wrong");
  a_fail_blk: assert property (p_fail_blk) else $error("block in failure wrong");
  a_misalign: assert property (p_misalign) else $error("misalignment wrong");
  a_reject: assert property (p_reject) else $error("ident not rejected");
  a_spare: assert property (p_spare) else $error("spare bit wrong");
  a_info: assert property (p_info) else $error("info request outside ident");
  a_id: assert property (p_id) else $error("link id wrong");
  a_intfail: assert property (p_intfail) else $error("internal failure wrong");
  property p_ident_ans;
    mgmt_out.ident_ok_ind || mgmt_out.ident_fail_ind |-> peer_msg.ident_release && link_state == ST_OPER
      && !(mgmt_out.ident_ok_ind && mgmt_out.ident_fail_ind);
  endproperty
  a_ident_ans: assert property (p_ident_ans) else $error("ident answer not released");
endmodule
bind link_control_fsm link_control_fsm_chk i_link_control_fsm_chk (.core_clk(core_clk), .rstn(rstn),
  .clk_en(clk_en), .link_id(link_id), .l1_in(l1_in), .mgmt_in(mgmt_in), .peer_in(peer_in),
  .peer_msg(peer_msg), .mgmt_out(mgmt_out), .layer1_ident_info_req(layer1_ident_info_req),
  .ident_spare_bit(ident_spare_bit), .link_operational(link_operational), .cchan_allowed(cchan_allowed),
  .bearer_allowed(bearer_allowed), .link_state(link_state));
`default_nettype wire

// File: link_peer_model.sv
// far-end peer: answers unblock, block requests and identification
`timescale 1ns/1ps
`default_nettype none
module link_peer_model
  import link_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic on,
  input wire logic [3:0] delay,
  input wire peer_msg_t peer_msg,
  output peer_evt_t peer_out
);
  peer_evt_t ans_reg;
  logic [3:0] cnt_reg;
  always @(posedge core_clk) begin
    peer_out <= '0;
    if (!rstn || !on) begin
      ans_reg <= '0;
    end else if (ans_reg != '0) begin
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == 4'h0) begin
        peer_out <= ans_reg;
        ans_reg <= '0;
      end
    end else begin
      cnt_reg <= delay;
      ans_reg.exchange_unblock_elem <= peer_msg.access_unblock_elem;
      ans_reg.block_ind <= peer_msg.block_req_deferred || peer_msg.block_req_nondeferred;
      ans_reg.peer_ident_ack <= peer_msg.peer_ident_request;
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the link control state machine
`timescale 1ns/1ps
`default_nettype none
module testbench
  import link_ctrl_pkg::*;
;
  logic core_clk;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic on = 1'b1;
  logic ans_ok = 1'b0;
  logic info_req;
  logic spare;
  logic [3:0] delay = 4'h0;
  logic [7:0] link_id = 8'h00;
  l1_evt_t l1 = '0;
  l1_evt_t l1_ans = '0;
  mgmt_evt_t mg = '0;
  peer_evt_t tbp = '0;
  peer_evt_t pm_out;
  peer_evt_t peer_in;
  peer_msg_t peer_msg;
  mgmt_out_t mgmt_out;
  link_state_t link_state;
  link_state_t last_st = ST_BLOCKED;
  link_state_t cur = ST_BLOCKED;
  link_state_t exp_q[$];
  int sv[4] = '{1, 1, 2, 2};
  int bv[4] = '{8, 4, 5, 3};
  int n_mismatch = 0;
  int checked = 0;
  assign peer_in = tbp | pm_out;
  link_control_fsm i_link_control_fsm (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .link_id(link_id),
    .l1_in(l1 | l1_ans), .mgmt_in(mg), .peer_in(peer_in), .peer_msg(peer_msg), .mgmt_out(mgmt_out),
    .layer1_ident_info_req(info_req), .ident_spare_bit(spare), .link_operational(), .cchan_allowed(),
    .bearer_allowed(), .link_state(link_state));
  link_peer_model i_link_peer_model (.core_clk(core_clk), .rstn(rstn), .on(on), .delay(delay),
    .peer_msg(peer_msg), .peer_out(pm_out));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] expv);
    checked++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, expv, seen);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic exp(input link_state_t e);
    if (e !== cur) exp_q.push_back(e);
    cur = e;
  endtask
  // one pulse on source 0 layer 1, 1 management, 2 peer
  task automatic ev(input int src, input int b);
    @(posedge core_clk);
    delay <= 4'($urandom_range(15, 0));
    ans_ok <= 1'($urandom);
    if (src == 0) l1[b] <= 1'b1;
    else if (src == 1) mg[b] <= 1'b1;
    else tbp[b] <= 1'b1;
    @(posedge core_clk);
    l1 <= '0;
    mg <= '0;
    tbp <= '0;
    repeat (30) @(posedge core_clk);
  endtask
  // each state change is taken against the oldest noted expectation
  always @(posedge core_clk) begin
    l1_ans <= info_req ? l1_evt_t'({2'b00, ans_ok, !ans_ok}) : '0;
    if (rstn && link_state !== last_st) begin
      if (exp_q.size() == 0) chk("state", link_state, last_st);
      else chk("state", link_state, exp_q.pop_front());
    end
    last_st <= link_state;
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    void'($urandom(19));
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    link_id <= 8'($urandom);
    @(posedge core_clk);
    chk("state", link_state, ST_BLOCKED);
    chk("spare", spare, 1'b1);
    ev(1, 3);
    ev(2, 3);
    exp(ST_FAIL_BLOCKED);
    ev(0, 3);
    exp(ST_BLOCKED);
    ev(0, 2);
    clk_en <= 1'b0;
    ev(1, 4);
    clk_en <= 1'b1;
    on <= 1'b0;
    exp(ST_LOCAL_UNBLK);
    ev(1, 4);
    for (int i = 0; i < 4; i++) begin
      exp(ST_FAIL);
      ev(0, 3);
      exp(ST_FAIL_BLOCKED);
      ev(sv[i], bv[i]);
      exp(ST_BLOCKED);
      ev(0, 2);
      exp(ST_LOCAL_UNBLK);
      ev(1, 4);
    end
    exp(ST_OPER);
    ev(2, 5);
    chk("link id", peer_msg.link_id, link_id);
    on <= 1'b1;
    repeat (3) begin
      exp(ST_LOCAL_IDENT);
      exp(ST_OPER);
      ev(1, 3);
    end
    exp(ST_REMOTE_IDENT);
    ev(2, 3);
    ev(1, 2);
    chk("spare", spare, 1'b0);
    exp(ST_OPER);
    ev(2, 1);
    on <= 1'b0;
    exp(ST_LOCAL_IDENT);
    ev(1, 3);
    exp(ST_OPER);
    ev(2, 3);
    ev(1, 1);
    on <= 1'b1;
    for (int i = 6; i < 8; i++) begin
      exp(ST_BLOCKED);
      ev(1, i);
      exp(ST_LOCAL_UNBLK);
      exp(ST_OPER);
      ev(1, 4);
    end
    exp(ST_BLOCKED);
    ev(1, 5);
    on <= 1'b0;
    exp(ST_REMOTE_UNBLK);
    ev(2, 5);
    exp(ST_OPER);
    ev(1, 4);
    on <= 1'b1;
    exp(ST_BLOCKED);
    ev(1, 0);
    exp(ST_LOCAL_UNBLK);
    exp(ST_OPER);
    ev(1, 4);
    rstn <= 1'b0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    cur = ST_BLOCKED;
    repeat (2) @(posedge core_clk);
    chk("state", link_state, ST_BLOCKED);
    chk("queue", 8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
